// *** hdl/sprw_pkg.sv ***
package sprw_pkg;

    // Register indices; each register takes one aligned word, so the byte address is four times the index
    localparam int IDX_GENERAL_CFG   = 2;
    localparam int IDX_DEVICE_STATUS = 4;
    localparam int IDX_THOLD_HIGH    = 5;
    localparam int IDX_THOLD_LOW     = 6;
    localparam int IDX_WDOG_CFG      = 7;

    // Register offsets, byte addresses on the APB
    localparam logic [7:0] ADDR_GENERAL_CFG   = 8'(IDX_GENERAL_CFG * 4);
    localparam logic [7:0] ADDR_DEVICE_STATUS = 8'(IDX_DEVICE_STATUS * 4);
    localparam logic [7:0] ADDR_THOLD_HIGH    = 8'(IDX_THOLD_HIGH * 4);
    localparam logic [7:0] ADDR_THOLD_LOW     = 8'(IDX_THOLD_LOW * 4);
    localparam logic [7:0] ADDR_WDOG_CFG      = 8'(IDX_WDOG_CFG * 4);
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h20;
    localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h24;
    localparam logic [7:0] ADDR_IRQ_CLEAR     = 8'h28;
    localparam logic [7:0] ADDR_RELOAD        = 8'h2c;

    // Field positions
    localparam int BIT_CKSUM_OK     = 7;
    localparam int BIT_INIT_DONE    = 6;
    localparam int BIT_REF_VALID    = 4;
    localparam int BIT_PARITY_EN    = 1;
    localparam int BIT_TIMER_OFF    = 0;
    localparam int BIT_RELOAD       = 2;
    localparam int WDOG_TO_LSB      = 1;
    localparam int WDOG_TO_MSB      = 7;

    // Reset values
    localparam logic [7:0] RST_THOLD_HIGH = 8'h01;
    localparam logic [7:0] RST_THOLD_LOW  = 8'h00;
    localparam logic [6:0] RST_WDOG_TO    = 7'h7f;
    localparam logic [7:0] RST_GENERAL    = 8'h02;

    // Timing
    localparam int CLK_HZ         = 40_000_000;
    localparam int WDOG_UNIT_MS   = 2;
    localparam int WDOG_UNIT_CYC  = CLK_HZ / 1000 * WDOG_UNIT_MS;
    localparam int REF_WIN_US     = 10;
    localparam int REF_WIN_CYC    = CLK_HZ / 1_000_000 * REF_WIN_US;
    localparam int REF_MIN_MHZ    = 12;
    localparam int REF_MAX_MHZ    = 64;
    localparam int REF_MIN_EDGES  = REF_MIN_MHZ * REF_WIN_US;
    localparam int REF_MAX_EDGES  = REF_MAX_MHZ * REF_WIN_US;
    localparam int LOAD_CYC       = 16;

    // Interrupt bits
    localparam int IRQ_INIT_DONE  = 0;
    localparam int IRQ_WDOG       = 1;
    localparam int IRQ_PARITY     = 2;
    localparam int IRQ_REF_LOST   = 3;
    localparam int IRQ_W          = 4;

    typedef enum logic [2:0] {
        LOAD_IDLE = 3'b001,
        LOAD_BUSY = 3'b010,
        LOAD_DONE = 3'b100
    } sprw_load_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sprw_apb_req_t;

endpackage

// *** hdl/sprw_regs.sv ***
// How it works
// RULE1 - Checksum-ok bit 7 set after load only if stored configuration checksum valid.
// RULE2 - Init-done bit 6 set once configuration load fully completes.
// RULE3 - Bit 4 high while reference clock measures between 12 and 64 MHz.
// RULE4 - Threshold is high byte bits 15:8 and low byte bits 7:0.
// RULE5 - Each port flags parity error when its count reaches the threshold.
// RULE6 - Threshold resets to high 0x1, low 0x0; both bytes read and write.
// RULE7 - Watchdog ends control-channel transactions that outlast the programmed timeout.
// RULE8 - Timeout is bits 7:1 of watchdog config, two milliseconds per count.
// RULE9 - Timeout field resets to 0x7F; software should never write zero.
// RULE10 - Watchdog config bit 0 disables the watchdog when one; resets zero.
// RULE11 - Parity errors counted only while general config bit 1 is set.
// RULE12 - Software polls init-done after requesting a reload with restart bit 2.
// RULE13 - Status register ignores writes; reserved bits read zero.
`timescale 1ns/100ps
`default_nettype none
module sprw_regs
    import sprw_pkg::*;
#(
    parameter int NPORTS        = 4,
    parameter int WDOG_UNIT_CNT = WDOG_UNIT_CYC
) (
    // Clock, reset, enable
    input  wire logic              mclk_i,
    input  wire logic              arst_n_i,
    input  wire logic              clk_en_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Configuration store
    input  wire logic              cfg_checksum_ok_i,
    // Reference clock, sampled as a level
    input  wire logic              reference_clock_input_i,
    // Receive ports
    input  wire logic [NPORTS-1:0] rx_parity_err_i,
    input  wire logic [NPORTS-1:0] port_cnt_clr_i,
    output logic [NPORTS-1:0]      parity_error_flag_o,
    // Control channel
    input  wire logic              cc_busy_i,
    output logic                   cc_abort_o,
    // Interrupt
    output logic                   irq_o
);

    typedef struct packed {
        logic [1:0]              rst_sync;
        sprw_load_t              load;
        logic [4:0]              load_cnt;
        logic                    cksum_ok;
        logic                    init_done;
        logic                    ref_valid;
        logic                    ref_prev;
        logic [15:0]             ref_win;
        logic [10:0]             ref_edges;
        logic [7:0]              general;
        logic [7:0]              thold_high;
        logic [7:0]              thold_low;
        logic [6:0]              wdog_to;
        logic                    wdog_off;
        logic [16:0]             unit_cnt;
        logic [6:0]              wdog_units;
        logic                    cc_abort;
        logic [NPORTS*16-1:0]    par_cnt;
        logic [NPORTS-1:0]       par_flag;
        logic [IRQ_W-1:0]        irq_sts;
        logic [IRQ_W-1:0]        irq_en;
        logic                    irq;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
    } sprw_state_t;

    sprw_state_t   cur;
    sprw_state_t   next_cur;
    sprw_apb_req_t req;
    logic          rst_n;

    assign req   = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};
    assign rst_n = cur.rst_sync[1];

    always_comb begin
        logic [15:0]       thold;
        logic [IRQ_W-1:0]  ev;
        logic [7:0]        rd;
        logic              hit;
        logic              wr;
        logic              rd_en;
        logic              ref_rise;
        logic [15:0]       cnt;
        next_cur = cur;
        thold    = {cur.thold_high, cur.thold_low}; // RULE4
        ev       = '0;
        rd       = '0;
        hit      = 1'b1;
        wr       = req.psel && req.penable && !cur.pready && req.pwrite;
        rd_en    = req.psel && req.penable && !cur.pready && !req.pwrite;
        ref_rise = reference_clock_input_i && !cur.ref_prev;
        cnt      = '0;
        next_cur.rst_sync = {cur.rst_sync[0], 1'b1};

        // Configuration load sequence; a reload request repeats it
        case (cur.load)
            LOAD_IDLE: begin
                next_cur.load     = LOAD_BUSY;
                next_cur.load_cnt = '0;
            end
            LOAD_BUSY: begin
                next_cur.load_cnt = cur.load_cnt + 5'h01;
                if (cur.load_cnt == 5'(LOAD_CYC - 1)) begin
                    next_cur.load      = LOAD_DONE;
                    next_cur.init_done = 1'b1; // RULE2
                    next_cur.cksum_ok  = cfg_checksum_ok_i; // RULE1
                    ev[IRQ_INIT_DONE]  = 1'b1;
                end
            end
            LOAD_DONE: begin
                if (wr && req.paddr == ADDR_RELOAD && req.pwdata[BIT_RELOAD]) begin
                    next_cur.load      = LOAD_IDLE; // RULE12
                    next_cur.init_done = 1'b0;
                    next_cur.cksum_ok  = 1'b0;
                end
            end
            default: next_cur.load = LOAD_IDLE;
        endcase

        // Reference frequency: count rising edges over a fixed window
        next_cur.ref_prev = reference_clock_input_i;
        if (ref_rise && cur.ref_edges != '1)
            next_cur.ref_edges = cur.ref_edges + 11'h001;
        if (cur.ref_win == 16'(REF_WIN_CYC - 1)) begin
            next_cur.ref_win   = '0;
            next_cur.ref_edges = '0;
            next_cur.ref_valid = (cur.ref_edges >= 11'(REF_MIN_EDGES))
                              && (cur.ref_edges <= 11'(REF_MAX_EDGES)); // RULE3
            if (cur.ref_valid && !next_cur.ref_valid)
                ev[IRQ_REF_LOST] = 1'b1;
        end else begin
            next_cur.ref_win = cur.ref_win + 16'h0001;
        end

        // Per-port parity counters, saturating
        for (int p = 0; p < NPORTS; p++) begin
            cnt = cur.par_cnt[p*16 +: 16];
            if (port_cnt_clr_i[p]) begin
                cnt = '0;
                next_cur.par_flag[p] = 1'b0;
            end else if (rx_parity_err_i[p] && cur.general[BIT_PARITY_EN] && cnt != '1) begin
                cnt = cnt + 16'h0001; // RULE11
            end
            next_cur.par_cnt[p*16 +: 16] = cnt;
            if (cnt >= thold) begin
                next_cur.par_flag[p] = 1'b1; // RULE5
                if (!cur.par_flag[p])
                    ev[IRQ_PARITY] = 1'b1;
            end
        end

        // Watchdog: counts 2 ms units while a transaction is open
        next_cur.cc_abort = 1'b0;
        if (!cc_busy_i || cur.wdog_off) begin // RULE10
            next_cur.unit_cnt   = '0;
            next_cur.wdog_units = '0;
        end else if (cur.unit_cnt == 17'(WDOG_UNIT_CNT - 1)) begin
            next_cur.unit_cnt = '0;
            if (cur.wdog_units + 7'h01 >= cur.wdog_to) begin // RULE8
                next_cur.cc_abort   = 1'b1; // RULE7
                next_cur.wdog_units = '0;
                ev[IRQ_WDOG]        = 1'b1;
            end else begin
                next_cur.wdog_units = cur.wdog_units + 7'h01;
            end
        end else begin
            next_cur.unit_cnt = cur.unit_cnt + 17'h00001;
        end

        // APB: one wait state, answer in the cycle after the access phase begins
        next_cur.pready  = 1'b0;
        next_cur.pslverr = 1'b0;
        case (req.paddr)
            ADDR_GENERAL_CFG:   rd = cur.general;
            ADDR_DEVICE_STATUS: begin
                rd[BIT_CKSUM_OK]  = cur.cksum_ok;
                rd[BIT_INIT_DONE] = cur.init_done;
                rd[BIT_REF_VALID] = cur.ref_valid; // RULE13
            end
            ADDR_THOLD_HIGH:    rd = cur.thold_high; // RULE6
            ADDR_THOLD_LOW:     rd = cur.thold_low; // RULE6
            ADDR_WDOG_CFG:      rd = {cur.wdog_to, cur.wdog_off};
            ADDR_IRQ_STATUS:    rd = 8'(cur.irq_sts);
            ADDR_IRQ_ENABLE:    rd = 8'(cur.irq_en);
            ADDR_IRQ_CLEAR:     rd = '0;
            ADDR_RELOAD:        rd = '0;
            default:            hit = 1'b0;
        endcase
        if (wr || rd_en) begin
            next_cur.pready  = 1'b1;
            next_cur.pslverr = !hit;
            next_cur.prdata  = rd_en ? {24'h000000, rd} : '0;
        end
        if (wr) begin
            case (req.paddr)
                ADDR_GENERAL_CFG: next_cur.general    = req.pwdata[7:0];
                ADDR_THOLD_HIGH:  next_cur.thold_high = req.pwdata[7:0]; // RULE6
                ADDR_THOLD_LOW:   next_cur.thold_low  = req.pwdata[7:0]; // RULE6
                ADDR_WDOG_CFG: begin
                    next_cur.wdog_to  = req.pwdata[WDOG_TO_MSB:WDOG_TO_LSB]; // RULE9
                    next_cur.wdog_off = req.pwdata[BIT_TIMER_OFF]; // RULE10
                end
                ADDR_IRQ_ENABLE:  next_cur.irq_en = req.pwdata[IRQ_W-1:0];
                ADDR_IRQ_CLEAR:   next_cur.irq_sts = cur.irq_sts & ~req.pwdata[IRQ_W-1:0];
                default: ; // Status register and unmapped writes are dropped
            endcase
        end
        // Set wins over a clear in the same cycle
        next_cur.irq_sts = next_cur.irq_sts | ev;
        next_cur.irq     = |(next_cur.irq_sts & next_cur.irq_en);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur            <= '0;
            cur.load       <= LOAD_IDLE;
            cur.general    <= RST_GENERAL;
            cur.thold_high <= RST_THOLD_HIGH; // RULE6
            cur.thold_low  <= RST_THOLD_LOW;
            cur.wdog_to    <= RST_WDOG_TO; // RULE9
        end else if (clk_en_i) begin
            if (!rst_n) begin
                cur.rst_sync <= next_cur.rst_sync;
            end else begin
                cur <= next_cur;
            end
        end
    end

    assign prdata_o            = cur.prdata;
    assign pready_o            = cur.pready;
    assign pslverr_o           = cur.pslverr;
    assign parity_error_flag_o = cur.par_flag;
    assign cc_abort_o          = cur.cc_abort;
    assign irq_o               = cur.irq;

endmodule
`default_nettype wire

// *** verif/sprw_regs_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module sprw_regs_sva
    import sprw_pkg::*;
#(
    parameter int NPORTS = 4
) (
    // Clock and reset
    input wire logic              mclk_i,
    input wire logic              arst_n_i,
    input wire logic              clk_en_i,
    // APB
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [7:0]        paddr_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    // Ports and control channel
    input wire logic [NPORTS-1:0] port_cnt_clr_i,
    input wire logic [NPORTS-1:0] parity_error_flag_o,
    input wire logic              cc_busy_i,
    input wire logic              cc_abort_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    a_ready_after_take: assert property (psel_i && penable_i && !pready_o && clk_en_i |=> pready_o)
        else $error("pready missing one cycle after access");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside an access");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    a_rdata_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_status_reserved_zero: assert property (pready_o && !pwrite_i && paddr_i == ADDR_DEVICE_STATUS |->
        prdata_o[5] == 1'b0 && prdata_o[3:0] == 4'h0)
        else $error("status reserved bits not zero");
    a_abort_single: assert property (cc_abort_o |=> !cc_abort_o)
        else $error("abort longer than one cycle");
    a_abort_needs_busy: assert property ($rose(cc_abort_o) |-> $past(cc_busy_i))
        else $error("abort without open transaction");
    a_flag_sticky: assert property (~|($past(parity_error_flag_o) & ~parity_error_flag_o
        & ~$past(port_cnt_clr_i)))
        else $error("parity flag fell without clear");
endmodule

bind sprw_regs sprw_regs_sva #(.NPORTS(NPORTS)) u_sva (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .port_cnt_clr_i(port_cnt_clr_i),
    .parity_error_flag_o(parity_error_flag_o), .cc_busy_i(cc_busy_i), .cc_abort_o(cc_abort_o)
);
`default_nettype wire

// *** verif/test_status_parity_watchdog_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_status_parity_watchdog_regs
    import sprw_pkg::*;
;
    // Short watchdog unit keeps the run brief
    localparam int UNIT = 10;
    logic        mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, cksum_ok = 1'b1, ref_clk = 1'b0, ref_run = 1'b0;
    logic [3:0]  par_err = 4'h0, cnt_clr = 4'h0, flag;
    logic        cc_busy = 1'b0, cc_abort, irq;
    int          errors = 0, n_compared = 0, cyc = 0;

    sprw_regs #(.NPORTS(4), .WDOG_UNIT_CNT(UNIT)) dut_u (
        .mclk_i(mclk), .arst_n_i(arst_n), .clk_en_i(1'b1), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cfg_checksum_ok_i(cksum_ok), .reference_clock_input_i(ref_clk),
        .rx_parity_err_i(par_err), .port_cnt_clr_i(cnt_clr), .parity_error_flag_o(flag),
        .cc_busy_i(cc_busy), .cc_abort_o(cc_abort), .irq_o(irq)
    );

    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) if (ref_run) ref_clk <= ~ref_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until the edge that samples pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        // Sample pready at the rising edge, then release at that same edge
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h0, r, e);
        chk(r, exp);
    endtask

    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n) begin
            @(posedge mclk) par_err <= m;
            @(posedge mclk) par_err <= 4'h0;
        end
        repeat (3) @(posedge mclk);
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rd(ADDR_THOLD_HIGH, 32'h01);
        rd(ADDR_THOLD_LOW, 32'h00);
        rd(ADDR_WDOG_CFG, 32'hfe);
        rd(ADDR_DEVICE_STATUS, 32'hc0);
        wr(ADDR_DEVICE_STATUS, 8'hff);
        rd(ADDR_DEVICE_STATUS, 32'hc0);
        apb(1'b0, 8'h3c, 8'h0, r, e);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic t_parity;
        // Low byte first: a zero threshold would set every flag at once
        wr(ADDR_THOLD_LOW, 8'h02);
        wr(ADDR_THOLD_HIGH, 8'h00);
        rd(ADDR_THOLD_LOW, 32'h02);
        wr(ADDR_GENERAL_CFG, 8'h00);
        pulse(4'h8, 3);
        chk({28'h0, flag}, 32'h0);
        wr(ADDR_GENERAL_CFG, 8'h02);
        pulse(4'h8, 1);
        chk({28'h0, flag}, 32'h0);
        pulse(4'h8, 1);
        chk({28'h0, flag}, 32'h8);
        @(posedge mclk) cnt_clr <= 4'h8;
        @(posedge mclk) cnt_clr <= 4'h0;
        repeat (2) @(posedge mclk);
        chk({28'h0, flag}, 32'h0);
        wr(ADDR_THOLD_HIGH, 8'h01);
        pulse(4'h2, 257);
        chk({28'h0, flag}, 32'h0);
        pulse(4'h2, 1);
        chk({28'h0, flag}, 32'h2);
    endtask

    task automatic t_wdog;
        logic [31:0] r;
        logic e;
        int n;
        wr(ADDR_IRQ_ENABLE, 8'h02);
        wr(ADDR_WDOG_CFG, 8'h04);
        @(posedge mclk) cc_busy <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (cc_abort !== 1'b1 && n < 60);
        cc_busy <= 1'b0;
        chk(32'(n >= 2 * UNIT - 1 && n <= 2 * UNIT + 3), 32'h1);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, ADDR_IRQ_STATUS, 8'h0, r, e);
        chk(r & 32'h2, 32'h2);
        wr(ADDR_IRQ_CLEAR, 8'h02);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_WDOG_CFG, 8'h05);
        @(posedge mclk) cc_busy <= 1'b1;
        n = 0;
        repeat (80) begin
            @(posedge mclk);
            if (cc_abort === 1'b1) n++;
        end
        cc_busy <= 1'b0;
        chk(32'(n), 32'h0);
    endtask

    task automatic t_status;
        logic [31:0] r;
        logic e;
        int n;
        ref_run <= 1'b1;
        repeat (900) @(posedge mclk);
        rd(ADDR_DEVICE_STATUS, 32'hd0);
        ref_run <= 1'b0;
        repeat (900) @(posedge mclk);
        rd(ADDR_DEVICE_STATUS, 32'hc0);
        cksum_ok <= 1'b0;
        wr(ADDR_RELOAD, 8'h04);
        n = 0;
        do begin
            apb(1'b0, ADDR_DEVICE_STATUS, 8'h0, r, e);
            n++;
        end while (r[BIT_INIT_DONE] !== 1'b1 && n < 20);
        chk(r, 32'h40);
    endtask

    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (30) @(posedge mclk);
        t_reset();
        t_parity();
        t_wdog();
        t_status();
        report_and_stop();
    end
endmodule
`default_nettype wire
